// ### design/supply_switch_irq_vector.sv
`timescale 1ns/10ps
`default_nettype none
`include "supply_irq_vector_defines.svh"

module supply_switch_irq_vector (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // One-cycle event pulses from the supply logic
    input wire logic global_switch_flag_set_i,
    input wire logic primary_switch_flag_set_i,
    input wire logic first_backup_switch_flag_set_i,
    input wire logic second_backup_switch_flag_set_i,
    input wire logic first_backup_drop_flag_set_i,
    input wire logic second_backup_drop_flag_set_i,
    input wire logic monitor_done_flag_set_i,
    // Pulse back to the flag owners
    output logic flag_clear_o,
    output logic irq_o
);

    // ------------------------------------------------
    // State
    // ------------------------------------------------
    supply_irq_pkg::flags_t flags;
    supply_irq_pkg::flags_t next_flags;
    supply_irq_pkg::flags_t mask;
    supply_irq_pkg::flags_t next_mask;
    supply_irq_pkg::flags_t set_evt;
    supply_irq_pkg::vector_t supply_irq_vector;
    supply_irq_pkg::vector_t next_supply_irq_vector;
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic clear_pulse;
    logic next_clear_pulse;
    logic irq;
    logic next_irq;

    // ------------------------------------------------
    // Bus decode
    // ------------------------------------------------
    logic req;
    logic wr;
    logic vec_wr;
    logic stat_wr;
    logic mask_wr;

    // Holding off while ack is high keeps a held request from
    // being taken twice
    assign req = cyc_i & stb_i & ~ack;
    assign wr = req & we_i;
    // Any vector write clears, whatever the data or lanes
    assign vec_wr = wr & (adr_i == `VECTOR_OFFSET);
    assign stat_wr = wr & (adr_i == `STATUS_OFFSET) & sel_i[0];
    assign mask_wr = wr & (adr_i == `MASK_OFFSET) & sel_i[0];

    // ------------------------------------------------
    // Pending flags
    // ------------------------------------------------
    assign set_evt = {
        monitor_done_flag_set_i,
        second_backup_drop_flag_set_i,
        first_backup_drop_flag_set_i,
        second_backup_switch_flag_set_i,
        first_backup_switch_flag_set_i,
        primary_switch_flag_set_i,
        global_switch_flag_set_i
    };

    // An event in the clearing cycle survives the clear
    for (genvar g = 0; g < 7; g++) begin : g_flag
        assign next_flags[g] = set_evt[g]
            | (flags[g] & ~vec_wr & ~(stat_wr & dat_i[g]));
    end

    // ------------------------------------------------
    // Vector code
    // ------------------------------------------------
    function automatic supply_irq_pkg::vector_t code_of(input int idx);
        supply_irq_pkg::vector_t c;
        c = `CODE_NONE;
        case (idx)
            int'(supply_irq_pkg::FLAG_GLOBAL): begin
                c = `CODE_GLOBAL;
            end
            int'(supply_irq_pkg::FLAG_PRIMARY): begin
                c = `CODE_PRIMARY;
            end
            int'(supply_irq_pkg::FLAG_FIRST_SW): begin
                c = `CODE_FIRST_SW;
            end
            int'(supply_irq_pkg::FLAG_SECOND_SW): begin
                c = `CODE_SECOND_SW;
            end
            // The reserved code is skipped here
            int'(supply_irq_pkg::FLAG_FIRST_DROP): begin
                c = `CODE_FIRST_DROP;
            end
            int'(supply_irq_pkg::FLAG_SECOND_DROP): begin
                c = `CODE_SECOND_DROP;
            end
            int'(supply_irq_pkg::FLAG_MONITOR): begin
                c = `CODE_MONITOR;
            end
            default: begin
                c = `CODE_NONE;
            end
        endcase
        return c;
    endfunction

    // Scan from lowest priority up so the smallest code lands last
    always_comb begin
        next_supply_irq_vector = `CODE_NONE;
        for (int i = 6; i >= 0; i--) begin
            if (flags[i]) begin
                next_supply_irq_vector = code_of(i);
            end
        end
    end

    // ------------------------------------------------
    // Mask and interrupt
    // ------------------------------------------------
    always_comb begin
        next_mask = mask;
        if (mask_wr) begin
            next_mask = dat_i[6:0];
        end
        // Registered from next values so irq tracks the flags
        next_irq = |(next_flags & next_mask);
        next_clear_pulse = vec_wr;
    end

    // ------------------------------------------------
    // Bus answer
    // ------------------------------------------------
    always_comb begin
        next_ack = req;
        next_rdata = rdata;
        if (req) begin
            case (adr_i)
                `VECTOR_OFFSET: begin
                    // Reading never touches the flags
                    next_rdata = {16'h0000, supply_irq_vector};
                end
                `STATUS_OFFSET: begin
                    next_rdata = {25'h0000000, flags};
                end
                `MASK_OFFSET: begin
                    next_rdata = {25'h0000000, mask};
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ------------------------------------------------
    // Registers
    // ------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= `FLAGS_RESET;
            mask <= `MASK_RESET;
            supply_irq_vector <= `VECTOR_RESET;
            ack <= 1'b0;
            rdata <= 32'h00000000;
            clear_pulse <= 1'b0;
            irq <= 1'b0;
        end else begin
            flags <= next_flags;
            mask <= next_mask;
            supply_irq_vector <= next_supply_irq_vector;
            ack <= next_ack;
            rdata <= next_rdata;
            clear_pulse <= next_clear_pulse;
            irq <= next_irq;
        end
    end

    assign ack_o = ack;
    assign dat_o = rdata;
    assign flag_clear_o = clear_pulse;
    assign irq_o = irq;

endmodule // supply_switch_irq_vector
`default_nettype wire

// ### design/supply_irq_vector_defines.svh
// How it works
// - Read-only 16-bit even vector, resets zero
// - No pending flag reads code 00h
// - Global switch flag wins, code 02h
// - Switch codes 04h, 06h, 08h
// - Code 0Ah reserved, never presented
// - Drop codes 0Ch and 0Eh
// - Monitor 10h lowest; smaller code wins
// - Any vector write clears all flags
// - Monitor cycle done sets monitor flag
// - Flag bit 0 idle, 1 pending
`ifndef SUPPLY_IRQ_VECTOR_DEFINES_SVH
`define SUPPLY_IRQ_VECTOR_DEFINES_SVH

// ------------------------------------------------
// Register byte offsets
// ------------------------------------------------
`define VECTOR_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define MASK_OFFSET 8'h08

// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define VECTOR_RESET 16'h0000
`define FLAGS_RESET 7'h00
`define MASK_RESET 7'h00

// ------------------------------------------------
// Vector codes
// ------------------------------------------------
`define CODE_NONE 16'h0000
`define CODE_GLOBAL 16'h0002
`define CODE_PRIMARY 16'h0004
`define CODE_FIRST_SW 16'h0006
`define CODE_SECOND_SW 16'h0008
`define CODE_RESERVED 16'h000a
`define CODE_FIRST_DROP 16'h000c
`define CODE_SECOND_DROP 16'h000e
`define CODE_MONITOR 16'h0010

`endif

// ### design/supply_irq_pkg.sv
package supply_irq_pkg;

    // Flag positions; a lower position has a higher priority
    typedef enum {
        FLAG_GLOBAL,
        FLAG_PRIMARY,
        FLAG_FIRST_SW,
        FLAG_SECOND_SW,
        FLAG_FIRST_DROP,
        FLAG_SECOND_DROP,
        FLAG_MONITOR
    } flag_idx_e;

    typedef logic [6:0] flags_t;
    typedef logic [15:0] vector_t;

endpackage

// ### sim/supply_vector_chk.sv
`timescale 1ns/10ps
`default_nettype none
module supply_vector_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic global_switch_flag_set_i,
    input wire logic monitor_done_flag_set_i,
    input wire logic flag_clear_o
);
    // ----
    // Checks
    // ----
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic take;
    logic vec_rd;
    assign take = cyc_i && stb_i && !ack_o;
    assign vec_rd = ack_o && !we_i && adr_i == 8'h00;
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (take |=> ack_o)
        else $error("request not answered");
    even_code_a: assert property (vec_rd |-> dat_o[0] == 1'b0 && dat_o[31:5] == 27'h0)
        else $error("vector odd or too wide");
    reserved_code_a: assert property (vec_rd |-> dat_o[15:0] != 16'h000a)
        else $error("reserved vector code seen");
    global_wins_a: assert property (global_switch_flag_set_i ##2 (take && !we_i && adr_i == 8'h00)
        |=> dat_o[15:0] == 16'h0002) else $error("global flag not first");
    monitor_sets_a: assert property (monitor_done_flag_set_i ##2 (take && !we_i && adr_i == 8'h00)
        |=> dat_o[15:0] != 16'h0000) else $error("monitor event not pending");
    clear_pulse_a: assert property ((take && we_i && adr_i == 8'h00) |=> flag_clear_o)
        else $error("vector write did not clear");
    clear_cause_a: assert property (flag_clear_o |-> ack_o && we_i && adr_i == 8'h00)
        else $error("clear without vector write");
endmodule // supply_vector_chk
bind supply_switch_irq_vector supply_vector_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .flag_clear_o(flag_clear_o),
    .global_switch_flag_set_i(global_switch_flag_set_i), .monitor_done_flag_set_i(monitor_done_flag_set_i));
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, flag_clear_o, irq_o;
    logic [6:0] ev = 7'h00, m;
    int mismatches = 0, checks = 0, i;
    int clears = 0;
    logic [15:0] codes [7] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000c, 16'h000e, 16'h0010};
    always #2 clk_i = ~clk_i;
    always @(negedge clk_i) clears += int'(flag_clear_o === 1'b1);
    supply_switch_irq_vector dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .global_switch_flag_set_i(ev[0]), .primary_switch_flag_set_i(ev[1]),
        .first_backup_switch_flag_set_i(ev[2]), .second_backup_switch_flag_set_i(ev[3]),
        .first_backup_drop_flag_set_i(ev[4]), .second_backup_drop_flag_set_i(ev[5]),
        .monitor_done_flag_set_i(ev[6]), .flag_clear_o(flag_clear_o), .irq_o(irq_o));
    // ----
    // Tasks
    // ----
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Holds the request until ack is sampled; the bound cuts a hung slave short
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, d};
        // Looked at mid-cycle, where ack and data have settled
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            mismatches++;
            test_done();
        end
        q = dat_o;
        @(posedge clk_i);
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic pulse(input logic [6:0] p);
        @(posedge clk_i);
        ev <= p;
        @(posedge clk_i);
        ev <= 7'h00;
        repeat (3) @(posedge clk_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0, rd);
        chk("vector after reset", rd, 32'h0);
        wb(1'b1, 8'h0c, 32'hffff_ffff, rd);
        wb(1'b0, 8'h0c, 32'h0, rd);
        chk("unmapped read", rd, 32'h0);
        // Each pass leaves the winner plus every lower source pending
        for (i = 0; i < 7; i++) begin
            m = 7'h7f << i;
            pulse(m);
            wb(1'b0, 8'h04, 32'h0, rd);
            chk("pending flags", rd, {25'h0, m});
            repeat (2) begin
                wb(1'b0, 8'h00, 32'h0, rd);
                chk("vector code", rd, {16'h0, codes[i]});
            end
            wb(1'b1, 8'h00, 32'h0000_a5a5, rd);
            wb(1'b0, 8'h00, 32'h0, rd);
            chk("vector after clear", rd, 32'h0);
        end
        wb(1'b1, 8'h08, 32'h40, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        chk("mask readback", rd, 32'h40);
        pulse(7'h41);
        chk("irq raised", {31'h0, irq_o}, 32'h1);
        wb(1'b1, 8'h04, 32'h40, rd);
        @(posedge clk_i);
        chk("irq after w1c", {31'h0, irq_o}, 32'h0);
        wb(1'b0, 8'h04, 32'h0, rd);
        chk("status after w1c", rd, 32'h1);
        wb(1'b1, 8'h08, 32'h0, rd);
        pulse(7'h40);
        chk("irq masked", {31'h0, irq_o}, 32'h0);
        wb(1'b1, 8'h00, 32'h0, rd);
        @(posedge clk_i);
        ev <= 7'h41;
        @(posedge clk_i);
        ev <= 7'h00;
        wb(1'b0, 8'h00, 32'h0, rd);
        chk("vector soon after event", rd, 32'h2);
        chk("clear pulses", clears, 32'h8);
        test_done();
    end
endmodule // testbench
`default_nettype wire
